//--- rtl/dflash_cmd_pkg.sv
// Shared constants and types for the data-flash command sequencer.
package dflash_cmd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB).
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_INDEX = 8'h04;
  localparam logic [7:0] OFS_PARAM = 8'h08;
  localparam logic [7:0] OFS_PROTECT = 8'h0C;

  // Status register bit positions.
  localparam int BIT_CCF = 7;
  localparam int BIT_ACCESS_ERROR_FLAG = 5;
  localparam int BIT_PROTECTION_VIOLATION_FLAG = 4;
  localparam int BIT_MG1 = 1;
  localparam int BIT_MG0 = 0;
  // Protection register: enable bit and lower bound of protected area.
  localparam int BIT_PROT_EN = 31;

  // Reset values.
  localparam logic [15:0] PROT_LIMIT_RST = 16'h8000;
  localparam logic PROT_EN_RST = 1'b0;

  // ----------------------------------------------------------------
  // Command codes and parameter index values.
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
  localparam logic [7:0] CMD_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
  localparam logic [2:0] IDX_SECTOR = 3'h1;
  localparam logic [2:0] IDX_VERIFY = 3'h2;
  localparam logic [2:0] IDX_PROG_MIN = 3'h2;
  localparam logic [2:0] IDX_PROG_MAX = 3'h5;
  localparam int NUM_PARAM_WORDS = 6;

  // ----------------------------------------------------------------
  // Data-flash map.
  // ----------------------------------------------------------------
  localparam logic [6:0] DF_BLOCK_HI = 7'h10;
  localparam logic [15:0] DF_LAST_ADDR = 16'h7FFF;
  localparam logic [15:0] DF_SECTOR_BYTES = 16'h0100;
  localparam logic [15:0] DF_SECTOR_WORDS = 16'h0080;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // Array operations requested from the flash macro.
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_ERASE = 2'b10,
    ST_READ = 2'b11
  } seq_state_e;

endpackage

//--- rtl/dflash_launch_check.sv
// Launch-time parameter, range, mode and protection checks.
`timescale 1ns/10ps
module dflash_launch_check
  import dflash_cmd_pkg::*;
(
  input wire logic [15:0] word0,
  input wire logic [15:0] word1,
  input wire logic [15:0] word2,
  input wire logic [2:0] launch_idx,
  input wire logic mode_permits,
  input wire logic prot_en,
  input wire logic [15:0] prot_limit,
  output logic acc_err,
  output logic prot_err,
  output logic [15:0] first_addr,
  output logic [15:0] word_count
);

  logic [17:0] end_ev;
  logic [17:0] end_pg;
  logic [15:0] sect_base;
  logic [15:0] sect_end;
  logic [7:0] code;
  logic addr_ok;

  // --------------------------------------------------------------
  // Address arithmetic, widened so an overflow cannot wrap back.
  // --------------------------------------------------------------
  assign code = word0[15:8];
  assign end_ev = {2'b00, word1} + {1'b0, word2, 1'b0} - 18'h0_0001;
  assign end_pg = {2'b00, word1} + {14'h0000, launch_idx - 3'h1, 1'b0} - 18'h0_0001;
  assign sect_base = word1 & ~(DF_SECTOR_BYTES - 16'h0001);
  assign sect_end = sect_base + DF_SECTOR_BYTES - 16'h0001;
  assign addr_ok = (word0[6:0] == DF_BLOCK_HI) && (word1 <= DF_LAST_ADDR);

  // Error decision per command; an unknown code is refused outright.
  always_comb begin
    acc_err = !mode_permits || !addr_ok;
    prot_err = 1'b0;
    first_addr = word1;
    word_count = 16'h0000;
    unique case (code)
      CMD_ERASE_VERIFY: begin
        // A zero count is refused: the range would end before it starts.
        if (launch_idx != IDX_VERIFY || word1[0] || word2 == 16'h0000 ||
            end_ev > {2'b00, DF_LAST_ADDR}) begin
          acc_err = 1'b1;
        end
        word_count = word2;
      end
      CMD_PROGRAM: begin
        if (launch_idx < IDX_PROG_MIN || launch_idx > IDX_PROG_MAX || word1[0] ||
            end_pg > {2'b00, DF_LAST_ADDR}) begin
          acc_err = 1'b1;
        end
        word_count = {13'h0000, launch_idx - 3'h1};
        prot_err = prot_en && (end_pg[15:0] >= prot_limit);
      end
      CMD_ERASE_SECTOR: begin
        if (launch_idx != IDX_SECTOR) begin
          acc_err = 1'b1;
        end
        first_addr = sect_base;
        word_count = DF_SECTOR_WORDS;
        prot_err = prot_en && (sect_end >= prot_limit);
      end
      default: acc_err = 1'b1;
    endcase
    // An access error outranks a protection violation.
    if (acc_err) begin
      prot_err = 1'b0;
    end
  end

endmodule // dflash_launch_check

//--- rtl/dflash_cmd_engine.sv
// Data-flash command sequencer: erase verify, word program and sector erase.
// Contract
// - Section check reads each word for erased state, then sets complete flag.
// - Section check with launch index other than 010 raises access error.
// - Section range past end of data-flash block raises access error.
// - Odd word address on section check or program raises access error.
// - Any 23-bit address outside the data-flash map raises access error.
// - Command not permitted in current mode or security raises access error.
// - Section check sets any-error bit on read error, uncorrectable bit likewise.
// - Launch index 010 to 101 selects one to four program words.
// - Program with launch index below 010 or above 101 raises access error.
// - Program group running past block end raises access error.
// - Protected target sets protection violation and leaves memory untouched.
// - Program reads words back; sets verify bits on error or uncorrectable error.
// - Complete flag sets once programming and verification are finished.
// - Sector erase erases all addresses, verifies, then sets complete flag.
// - Sector erase with launch index other than 001 raises access error.
// - Error while verifying erased sector sets the any-error bit.
// - Clearing the complete flag launches; zero flag means command running.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module dflash_cmd_engine
  import dflash_cmd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_permits,
  output logic arr_req,
  output logic [1:0] arr_op,
  output logic [22:0] arr_addr,
  output logic [15:0] arr_wdata,
  input wire logic arr_ack,
  input wire logic [15:0] arr_rdata,
  input wire logic arr_rd_err,
  input wire logic arr_rd_uncorr,
  output logic busy
);

  // ----------------------------------------------------------------
  // State record.
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_e st;
    logic ccf;
    logic access_error_flag;
    logic protection_violation_flag;
    logic mg1;
    logic mg0;
    logic [2:0] idx;
    logic [NUM_PARAM_WORDS-1:0][15:0] words;
    logic prot_en;
    logic [15:0] prot_limit;
    logic [15:0] addr;
    logic [15:0] remain;
    logic [1:0] wsel;
    logic [31:0] rdata;
  } engine_s;

  engine_s s_r;
  engine_s s_nxt;

  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic launch;
  logic chk_acc;
  logic chk_prot;
  logic [15:0] chk_addr;
  logic [15:0] chk_count;
  logic [15:0] expect_word;
  logic [7:0] cur_code;
  logic [31:0] read_mux;

  // ----------------------------------------------------------------
  // Bus decode. The slave never stalls, so every access ends at once.
  // ----------------------------------------------------------------
  assign mapped = (paddr == OFS_STATUS) || (paddr == OFS_INDEX) ||
                  (paddr == OFS_PARAM) || (paddr == OFS_PROTECT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  // Writing one to the complete flag while it is set starts a command.
  assign launch = wr_acc && (paddr == OFS_STATUS) && pwdata[BIT_CCF] && s_r.ccf;
  assign cur_code = s_r.words[0][15:8];
  assign prdata = s_r.rdata;
  assign busy = !s_r.ccf;

  // Launch checks on the loaded parameters.
  dflash_launch_check u_check (
    .word0(s_r.words[0]),
    .word1(s_r.words[1]),
    .word2(s_r.words[2]),
    .launch_idx(s_r.idx),
    .mode_permits(mode_permits),
    .prot_en(s_r.prot_en),
    .prot_limit(s_r.prot_limit),
    .acc_err(chk_acc),
    .prot_err(chk_prot),
    .first_addr(chk_addr),
    .word_count(chk_count)
  );

  // ----------------------------------------------------------------
  // Array request and read-back comparison.
  // ----------------------------------------------------------------
  assign arr_req = (s_r.st != ST_IDLE);
  assign arr_op = (s_r.st == ST_WRITE) ? OP_PROGRAM : (s_r.st == ST_ERASE) ? OP_ERASE : OP_READ;
  assign arr_addr = {s_r.words[0][6:0], s_r.addr};
  assign arr_wdata = s_r.words[3'(s_r.wsel) + 3'h2];
  assign expect_word = (cur_code == CMD_PROGRAM) ? s_r.words[3'(s_r.wsel) + 3'h2] : ERASED_WORD;

  // Register read data, selected during the setup cycle.
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_STATUS: begin
        read_mux[BIT_CCF] = s_r.ccf;
        read_mux[BIT_ACCESS_ERROR_FLAG] = s_r.access_error_flag;
        read_mux[BIT_PROTECTION_VIOLATION_FLAG] = s_r.protection_violation_flag;
        read_mux[BIT_MG1] = s_r.mg1;
        read_mux[BIT_MG0] = s_r.mg0;
      end
      OFS_INDEX: read_mux[2:0] = s_r.idx;
      OFS_PARAM: read_mux[15:0] = (s_r.idx < 3'(NUM_PARAM_WORDS)) ? s_r.words[s_r.idx] : 16'h0000;
      OFS_PROTECT: read_mux = {s_r.prot_en, 15'h0000, s_r.prot_limit};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic: bus writes, launch and the array sequence.
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (rd_setup) begin
      s_nxt.rdata = read_mux;
    end
    // Parameters are frozen while a command runs so it cannot be corrupted midway.
    if (wr_acc && s_r.ccf) begin
      if (paddr == OFS_INDEX) begin
        s_nxt.idx = pwdata[2:0];
      end
      if (paddr == OFS_PARAM && s_r.idx < 3'(NUM_PARAM_WORDS)) begin
        s_nxt.words[s_r.idx] = pwdata[15:0];
      end
      if (paddr == OFS_PROTECT) begin
        s_nxt.prot_en = pwdata[BIT_PROT_EN];
        s_nxt.prot_limit = pwdata[15:0];
      end
    end
    // Write-one-to-clear on the sticky error flags.
    if (wr_acc && paddr == OFS_STATUS) begin
      if (pwdata[BIT_ACCESS_ERROR_FLAG]) begin
        s_nxt.access_error_flag = 1'b0;
      end
      if (pwdata[BIT_PROTECTION_VIOLATION_FLAG]) begin
        s_nxt.protection_violation_flag = 1'b0;
      end
    end
    if (launch) begin
      // A new launch clears old results before the new ones are set.
      s_nxt.access_error_flag = chk_acc;
      s_nxt.protection_violation_flag = chk_prot;
      s_nxt.mg1 = 1'b0;
      s_nxt.mg0 = 1'b0;
      s_nxt.addr = chk_addr;
      s_nxt.remain = chk_count;
      s_nxt.wsel = 2'b00;
      if (chk_acc || chk_prot) begin
        s_nxt.ccf = 1'b1;
      end else begin
        s_nxt.ccf = 1'b0;
        unique case (cur_code)
          CMD_ERASE_VERIFY: s_nxt.st = ST_READ;
          CMD_PROGRAM: s_nxt.st = ST_WRITE;
          default: s_nxt.st = ST_ERASE;
        endcase
      end
    end
    if (arr_ack) begin
      unique case (s_r.st)
        ST_IDLE: s_nxt.st = ST_IDLE;
        ST_WRITE: s_nxt.st = ST_READ;
        ST_ERASE: s_nxt.st = ST_READ;
        ST_READ: begin
          // Verify results only ever set here, so a same-cycle clear cannot lose them.
          if (arr_rd_err || arr_rd_uncorr || arr_rdata != expect_word) begin
            s_nxt.mg1 = 1'b1;
          end
          if (arr_rd_uncorr) begin
            s_nxt.mg0 = 1'b1;
          end
          s_nxt.addr = s_r.addr + 16'h0002;
          s_nxt.remain = s_r.remain - 16'h0001;
          s_nxt.wsel = s_r.wsel + 2'b01;
          if (s_r.remain == 16'h0001) begin
            s_nxt.st = ST_IDLE;
            s_nxt.ccf = 1'b1;
          end else if (cur_code == CMD_PROGRAM) begin
            s_nxt.st = ST_WRITE;
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.ccf <= 1'b1;
      s_r.prot_en <= PROT_EN_RST;
      s_r.prot_limit <= PROT_LIMIT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  launch_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && (chk_acc || chk_prot) |=> s_r.ccf && !arr_req)
    else $error("refused launch did not leave complete flag set");

  busy_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.st != ST_IDLE) == !s_r.ccf)
    else $error("complete flag disagrees with sequencer state");

  verify_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && cur_code == CMD_ERASE_VERIFY && s_r.idx != IDX_VERIFY |=> s_r.access_error_flag && s_r.ccf)
    else $error("section check with wrong index not refused");

  prog_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && cur_code == CMD_PROGRAM && (s_r.idx < IDX_PROG_MIN || s_r.idx > IDX_PROG_MAX)
    |=> s_r.access_error_flag)
    else $error("program with out-of-range index not refused");

  sector_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && cur_code == CMD_ERASE_SECTOR && s_r.idx != IDX_SECTOR |=> s_r.access_error_flag)
    else $error("sector erase with wrong index not refused");

  protect_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && chk_prot |=> (s_r.protection_violation_flag && !arr_req) [*8])
    else $error("protected area touched or violation flag lost");

  mode_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && !mode_permits |=> s_r.access_error_flag && s_r.st == ST_IDLE)
    else $error("command ran in a mode that forbids it");

  misalign_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && s_r.words[1][0] && (cur_code == CMD_ERASE_VERIFY || cur_code == CMD_PROGRAM)
    |=> s_r.access_error_flag)
    else $error("odd word address not refused");

  mismatch_a: assert property (@(posedge pclk) disable iff (!presetn)
    arr_ack && s_r.st == ST_READ && arr_rdata != expect_word |=> s_r.mg1)
    else $error("read-back mismatch not reported");

  uncorr_a: assert property (@(posedge pclk) disable iff (!presetn)
    arr_ack && s_r.st == ST_READ && arr_rd_uncorr |=> s_r.mg0 && s_r.mg1)
    else $error("uncorrectable read not reported");

  prog_verify_a: assert property (@(posedge pclk) disable iff (!presetn)
    arr_ack && s_r.st == ST_WRITE |=> s_r.st == ST_READ && !s_r.ccf)
    else $error("program word not followed by its read-back");

  sector_walk_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && !chk_acc && !chk_prot && cur_code == CMD_ERASE_SECTOR
    |=> s_r.st == ST_ERASE && s_r.remain == DF_SECTOR_WORDS && s_r.addr[7:0] == 8'h00)
    else $error("sector erase did not start at sector base");

  // The range checks below recompute the limits here rather than trusting the checker's sums.
  block_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && s_r.words[0][6:0] != DF_BLOCK_HI |=> s_r.access_error_flag && s_r.ccf)
    else $error("launch outside the data-flash block not refused");

  section_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && cur_code == CMD_ERASE_VERIFY && ({2'b00, s_r.words[1]} + {1'b0, s_r.words[2], 1'b0}) > 18'h0_8000
    |=> s_r.access_error_flag)
    else $error("section check past block end not refused");

  group_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch && cur_code == CMD_PROGRAM && ({2'b00, s_r.words[1]} + {14'h0000, s_r.idx - 3'h1, 1'b0}) > 18'h0_8000
    |=> s_r.access_error_flag)
    else $error("program group past block end not refused");

  // Sticky results: only a clear by software or a new launch may drop them.
  error_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.access_error_flag && !launch && !(wr_acc && paddr == OFS_STATUS && pwdata[BIT_ACCESS_ERROR_FLAG]) |=> s_r.access_error_flag)
    else $error("access error flag dropped without a clear");

  verify_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.mg1 && !launch |=> s_r.mg1)
    else $error("verify error bit dropped without a launch");

endmodule // dflash_cmd_engine

//--- sim/tb_data_flash_command_engine.sv
// Self-checking bench for the data-flash command sequencer.
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_data_flash_command_engine;
  import dflash_cmd_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mode_permits = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, arr_req, busy, slv, seen;
  logic arr_ack = 0, arr_rd_err = 0, arr_rd_uncorr = 0, inj_err = 0, inj_unc = 0;
  logic [1:0] arr_op;
  logic [22:0] arr_addr;
  logic [15:0] arr_wdata;
  logic [15:0] arr_rdata = 16'h0000;
  logic [7:0] st;
  logic [15:0] mem [int];
  int errors = 0, compares = 0, cycles = 0, nops = 0, wait_cnt = 0, n0;

  // ----------------------------------------------------------------
  // Clock, design and array stand-in
  // ----------------------------------------------------------------
  // Free-running bus clock at 25 MHz.
  initial begin
    forever #20 pclk = ~pclk;
  end

  dflash_cmd_engine dflash_cmd_engine_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_permits(mode_permits), .arr_req(arr_req), .arr_op(arr_op), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_ack(arr_ack), .arr_rdata(arr_rdata), .arr_rd_err(arr_rd_err),
    .arr_rd_uncorr(arr_rd_uncorr), .busy(busy));

  // Array answers after 0 or 1 wait cycles in turn, so both prompt and slow acks are seen.
  always @(posedge pclk) begin
    arr_ack <= 1'b0;
    if (arr_req && !arr_ack) begin
      if (wait_cnt == nops % 2) begin
        arr_ack <= 1'b1;
        wait_cnt <= 0;
        nops <= nops + 1;
        arr_rd_err <= inj_err;
        arr_rd_uncorr <= inj_unc;
        arr_rdata <= mem.exists(arr_addr[15:0]) ? mem[arr_addr[15:0]] : ERASED_WORD;
        if (arr_op == OP_PROGRAM) mem[arr_addr[15:0]] = arr_wdata;
        if (arr_op == OP_ERASE) for (int i = 0; i < 256; i += 2) mem[{arr_addr[15:8], 8'h00} + i] = ERASED_WORD;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end

  // Cuts a hang short; the whole run needs a few thousand cycles.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus and command tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Loads nw parameter words, sets the launch index, launches and waits for completion.
  task automatic launch(input logic [15:0] w [6], input int nw, input logic [2:0] idx);
    int n;
    for (int i = 0; i < nw; i++) begin
      apb(1'b1, OFS_INDEX, 32'(i));
      apb(1'b1, OFS_PARAM, {16'h0000, w[i]});
    end
    apb(1'b1, OFS_INDEX, {29'h0000_0000, idx});
    n0 = nops;
    apb(1'b1, OFS_STATUS, 32'h0000_0080);
    @(negedge pclk);
    seen = busy;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    st = rd[7:0];
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK("status", 32'h0000_0080, rd)
    apb(1'b0, OFS_PROTECT, 32'h0000_0000);
    `CHK("protect", 32'h0000_8000, rd)
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, slv)
    $display("reset test done");
  endtask

  // Every launch index from one to four words, each group at its own address.
  task automatic t_program();
    logic [15:0] a;
    logic [15:0] p [6];
    for (int k = 2; k <= 5; k++) begin
      a = 16'h0200 + 16'(k * 16);
      p = '{16'h1110, a, 16'h1A00 + 16'(k), 16'h2B00, 16'h3C00, 16'h4D00};
      // Index k needs words 0 to k loaded, so k + 1 words go in.
      launch(p, k + 1, 3'(k));
      `CHK("busy seen", 1'b1, seen)
      `CHK("status", 8'h80, st)
      `CHK("ops", 2 * (k - 1), nops - n0)
      `CHK("word0", p[2], mem[a])
      `CHK("last word", p[k], mem[a + 16'(2 * (k - 2))])
      `CHK("past group", 1'b0, mem.exists(a + 16'(2 * (k - 1))))
    end
    $display("program test done");
  endtask

  // Launches that must be refused at once, one per row.
  task automatic t_refuse();
    logic [15:0] w0 [13] = '{16'h1010, 16'h1010, 16'h1010, 16'h1110, 16'h1011, 16'h1210, 16'h1110,
      16'h1110, 16'h1110, 16'h1210, 16'h1010, 16'h1010, 16'h1310};
    logic [15:0] w1 [13] = '{16'h0000, 16'h7FFE, 16'h0001, 16'h0003, 16'h0000, 16'h8000, 16'h0000,
      16'h0000, 16'h7FFC, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] w2 [13] = '{16'h0001, 16'h0002, 16'h0001, 16'h1234, 16'h0001, 16'h0000, 16'h1234,
      16'h1234, 16'h1234, 16'h0000, 16'h0000, 16'h0001, 16'h0001};
    logic [2:0] ix [13] = '{3'h3, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h6, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2};
    for (int r = 0; r < 13; r++) begin
      mode_permits <= (r != 11);
      launch('{w0[r], w1[r], w2[r], w2[r], w2[r], w2[r]}, 6, ix[r]);
      `CHK("refused status", 8'hA0, st)
      `CHK("refused busy", 1'b0, seen)
      `CHK("refused ops", 0, nops - n0)
    end
    mode_permits <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK("error held", 32'h0000_00A0, rd)
    apb(1'b1, OFS_STATUS, 32'h0000_0030);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK("error cleared", 32'h0000_0080, rd)
    $display("refusal test done");
  endtask

  // Protected area: no array operation and the violation flag alone.
  task automatic t_protect();
    apb(1'b1, OFS_PROTECT, 32'h8000_4000);
    launch('{16'h1110, 16'h4000, 16'h5555, 16'h0000, 16'h0000, 16'h0000}, 3, 3'h2);
    `CHK("prog protected", 8'h90, st)
    `CHK("prog untouched", 1'b0, mem.exists(16'h4000))
    launch('{16'h1210, 16'h4142, 16'h0000, 16'h0000, 16'h0000, 16'h0000}, 2, 3'h1);
    `CHK("erase protected", 8'h90, st)
    `CHK("erase ops", 0, nops - n0)
    apb(1'b1, OFS_PROTECT, 32'h0000_8000);
    $display("protection test done");
  endtask

  // Read-back results of the three commands, with injected read faults.
  task automatic t_verify();
    launch('{16'h1010, 16'h0220, 16'h0002, 16'h0000, 16'h0000, 16'h0000}, 3, 3'h2);
    `CHK("check dirty", 8'h82, st)
    launch('{16'h1010, 16'h1000, 16'h0004, 16'h0000, 16'h0000, 16'h0000}, 3, 3'h2);
    `CHK("check clean", 8'h80, st)
    `CHK("check reads", 4, nops - n0)
    inj_err <= 1'b1;
    inj_unc <= 1'b1;
    launch('{16'h1010, 16'h7FFE, 16'h0001, 16'h0000, 16'h0000, 16'h0000}, 3, 3'h2);
    `CHK("check uncorr", 8'h83, st)
    inj_unc <= 1'b0;
    launch('{16'h1110, 16'h1100, 16'h0F0F, 16'h0000, 16'h0000, 16'h0000}, 3, 3'h2);
    `CHK("prog read err", 8'h82, st)
    launch('{16'h1210, 16'h0300, 16'h0000, 16'h0000, 16'h0000, 16'h0000}, 2, 3'h1);
    `CHK("sector read err", 8'h82, st)
    inj_err <= 1'b0;
    launch('{16'h1210, 16'h0234, 16'h0000, 16'h0000, 16'h0000, 16'h0000}, 2, 3'h1);
    `CHK("sector status", 8'h80, st)
    `CHK("sector ops", 129, nops - n0)
    `CHK("sector erased", ERASED_WORD, mem[16'h0220])
    $display("verify test done");
  endtask

  // Main sequence: six-cycle reset, then each scenario.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_program();
    t_refuse();
    t_protect();
    t_verify();
    end_of_test();
  end
endmodule // tb_data_flash_command_engine
